// ===== hdl/serial_channel_irq.sv
// Interrupt request and source-flag logic of one serial channel.
`timescale 1ns/1ps
`include "serial_irq_regs.svh"
module serial_channel_irq
  import serial_irq_pkg::*;
#(
  parameter int FILL_W = `FILL_WIDTH
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Buffer levels and buffer access strobes.
  input wire logic [FILL_W-1:0] tx_fill_count,
  input wire logic [FILL_W-1:0] rx_fill_count,
  input wire logic tx_buffer_write,
  input wire logic rx_buffer_read,
  input wire logic rx_read_next_pmp,
  input wire logic rx_frame_last_read,
  // Channel events and line levels.
  input wire logic tx_underflow_event,
  input wire logic tx_quiet_event,
  input wire logic clear_to_send_level,
  input wire logic carrier_level,
  input wire logic [`RX_SRC_COUNT-1:0] rx_source_event,
  input wire logic check_code_ok,
  // Requests and interrupt.
  output logic tx_space_request,
  output logic rx_data_request,
  output logic tx_summary_request,
  output logic rx_summary_request,
  output logic irq
);

  // Elaboration refuses widths that the 8-bit threshold compare cannot hold.
  if (FILL_W < 1 || FILL_W > 8)
  begin : g_bad_fill
    $error("FILL_W must lie between 1 and 8");
  end

  logic [7:0] int_enable_reg;
  logic [`TX_SRC_COUNT-1:0] tx_src_en_reg;
  logic [`RX_SRC_COUNT-1:0] rx_src_en_reg;
  logic [`RX_SRC_COUNT-1:0] frame_result_reg;
  logic [7:0] tx_threshold_reg;
  logic [7:0] control_reg;
  logic [`IRQ_EVENT_COUNT-1:0] irq_mask_reg;
  logic tx_space_reg;
  logic rx_data_reg;
  logic cts_prev_reg;
  logic carrier_prev_reg;
  logic [1:0] pmp_zero_reg;
  logic [3:0] req_prev_reg;
  logic [`TX_SRC_COUNT-1:0] tx_src_flags;
  logic [`RX_SRC_COUNT-1:0] rx_src_flags;
  logic [`IRQ_EVENT_COUNT-1:0] irq_flags;
  logic [`TX_SRC_COUNT-1:0] tx_src_set;
  logic [`TX_SRC_COUNT-1:0] tx_src_w1c;
  logic [`TX_SRC_COUNT-1:0] tx_src_hw;
  logic [`RX_SRC_COUNT-1:0] rx_src_set;
  logic [`RX_SRC_COUNT-1:0] rx_src_w1c;
  logic [`RX_SRC_COUNT-1:0] rx_src_hw;
  logic [`IRQ_EVENT_COUNT-1:0] irq_w1c;
  logic [3:0] req_now;
  logic [7:0] status_zero;
  logic wr_en;
  logic access;
  logic chan_reset;
  logic tx_reset;
  logic rx_reset;
  logic tx_summary_flag;
  logic rx_summary_flag;
  logic frame_copy;
  logic pmp_read;
  logic pmp_clear;
  logic [1:0] pmp_need;
  logic [1:0] pmp_zero_next;
  logic addr_ok;
  logic [31:0] rd_data;
  proto_mode_e mode;

  // The answer comes one cycle into the access phase, so prdata is flopped.
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // Command bits are write pulses; they never stick in the control word.
  assign chan_reset = wr_en && paddr == `OFS_CONTROL &&
                      pwdata[`CTL_CHAN_RESET];
  assign tx_reset = wr_en && paddr == `OFS_CONTROL && pwdata[`CTL_TX_RESET];
  assign rx_reset = wr_en && paddr == `OFS_CONTROL && pwdata[`CTL_RX_RESET];

  // Mode decode; an illegal code falls back to asynchronous.
  always_comb
  begin
    case (control_reg[`CTL_MODE_LSB +: 3])
      3'h2: mode = MODE_BYTE_SYNC;
      3'h4: mode = MODE_BIT_SYNC;
      default: mode = MODE_ASYNC;
    endcase
  end

  // Summaries: each source gated by its own enable, then ORed.
  assign tx_summary_flag = |(tx_src_flags & tx_src_en_reg);
  assign rx_summary_flag = |(rx_src_flags & rx_src_en_reg);

  // First status word; summary bits ignore the summary enables.
  always_comb
  begin
    status_zero = 8'h00;
    status_zero[`BIT_TX_SUMMARY] = tx_summary_flag;
    status_zero[`BIT_RX_SUMMARY] = rx_summary_flag;
    status_zero[`BIT_RX_DATA] = rx_data_reg;
    status_zero[`BIT_TX_SPACE] = tx_space_reg;
  end

  // Request of each type is its flag ANDed with its enable.
  assign req_now = {status_zero[`BIT_TX_SUMMARY] &
                    int_enable_reg[`BIT_TX_SUMMARY],
                    status_zero[`BIT_RX_SUMMARY] &
                    int_enable_reg[`BIT_RX_SUMMARY],
                    status_zero[`BIT_RX_DATA] & int_enable_reg[`BIT_RX_DATA],
                    status_zero[`BIT_TX_SPACE] &
                    int_enable_reg[`BIT_TX_SPACE]};

  // Request outputs are flopped levels that follow flag and enable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_summary_request <= 1'b0;
      rx_summary_request <= 1'b0;
      rx_data_request <= 1'b0;
      tx_space_request <= 1'b0;
    end
    else
    begin
      tx_summary_request <= req_now[3];
      rx_summary_request <= req_now[2];
      rx_data_request <= req_now[1];
      tx_space_request <= req_now[0];
    end
  end

  // Transmit space: ready while the transmitter is enabled and the fill stays at or below the threshold.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_space_reg <= 1'b0;
    else if (chan_reset || tx_reset)
      tx_space_reg <= 1'b0;
    else
      tx_space_reg <= control_reg[`CTL_TX_ENABLE] &&
                      8'(tx_fill_count) <=
                      tx_threshold_reg;
  end

  // Receive data: held until the buffer has been read empty.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_data_reg <= 1'b0;
    else if (chan_reset || rx_reset)
      rx_data_reg <= 1'b0;
    else if (rx_fill_count != '0)
      rx_data_reg <= 1'b1;
    else
      rx_data_reg <= 1'b0;
  end

  // Previous line levels for change detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_prev_reg <= 1'b0;
      carrier_prev_reg <= 1'b0;
    end
    else
    begin
      cts_prev_reg <= clear_to_send_level;
      carrier_prev_reg <= carrier_level;
    end
  end

  // Transmit sources.
  assign tx_src_set = {clear_to_send_level != cts_prev_reg,
                       tx_quiet_event, tx_underflow_event};
  assign tx_src_w1c = (wr_en && paddr == `OFS_TX_SRC_STATUS) ?
                      pwdata[`TX_SRC_COUNT-1:0] : '0;
  assign tx_src_hw = {1'b0, tx_buffer_write, 1'b0};

  sticky_flag_bank #(
    .WIDTH(`TX_SRC_COUNT)
  ) u_tx_src (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(tx_src_set),
    .w1c_mask(tx_src_w1c),
    .hw_clear(tx_src_hw),
    .force_clear(chan_reset || tx_reset),
    .flags(tx_src_flags)
  );

  // The frame copy happens only in bit-sync mode, on the last byte read.
  assign frame_copy = mode == MODE_BIT_SYNC && rx_frame_last_read;

  // Parity bit source clears on reads only in asynchronous mode.
  assign pmp_read = mode == MODE_ASYNC && rx_buffer_read &&
                    rx_src_flags[`RX_PMP];
  assign pmp_need = control_reg[`CTL_SINGLE_BYTE_HOST] ? 2'd1 : 2'd2;
  assign pmp_zero_next = rx_read_next_pmp ? 2'd0 :
                         pmp_zero_reg + 2'd1;
  assign pmp_clear = pmp_read && pmp_zero_next >= pmp_need;

  // Count consecutive zero parity bits read while the flag is set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pmp_zero_reg <= 2'd0;
    else if (!rx_src_flags[`RX_PMP] || pmp_clear || chan_reset)
      pmp_zero_reg <= 2'd0;
    else if (pmp_read)
      pmp_zero_reg <= pmp_zero_next;
  end

  // Receive sources; line changes and the frame copy add their own sets.
  always_comb
  begin
    rx_src_set = rx_source_event;
    rx_src_set[`RX_CARRIER] = rx_source_event[`RX_CARRIER] ||
                              carrier_level != carrier_prev_reg;
    rx_src_set[`RX_FRAME_END_STATUS] = rx_source_event[`RX_FRAME_END_STATUS]
                                       || frame_copy;
    rx_src_hw = frame_copy ? `RX_FRAME_BITS : '0;
    rx_src_hw[`RX_PMP] = rx_src_hw[`RX_PMP] || pmp_clear;
    rx_src_hw[`RX_CRC] = rx_src_hw[`RX_CRC] ||
                         (mode != MODE_ASYNC && check_code_ok);
  end
  assign rx_src_w1c = (wr_en && paddr == `OFS_RX_SRC_STATUS) ?
                      pwdata[`RX_SRC_COUNT-1:0] : '0;

  sticky_flag_bank #(
    .WIDTH(`RX_SRC_COUNT)
  ) u_rx_src (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(rx_src_set),
    .w1c_mask(rx_src_w1c),
    .hw_clear(rx_src_hw),
    .force_clear(chan_reset || rx_reset),
    .flags(rx_src_flags)
  );

  // Frame result keeps the frame bits as they stood at the copy.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_result_reg <= '0;
    else if (chan_reset)
      frame_result_reg <= '0;
    else if (frame_copy)
      frame_result_reg <= rx_src_flags & `RX_FRAME_BITS;
  end

  // Interrupt events are rising request edges, caught even when unmasked later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_prev_reg <= 4'h0;
    else
      req_prev_reg <= req_now;
  end
  assign irq_w1c = (wr_en && paddr == `OFS_IRQ_STATUS) ?
                   pwdata[`IRQ_EVENT_COUNT-1:0] : '0;

  sticky_flag_bank #(
    .WIDTH(`IRQ_EVENT_COUNT)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(req_now & ~req_prev_reg),
    .w1c_mask(irq_w1c),
    .hw_clear('0),
    .force_clear(1'b0),
    .flags(irq_flags)
  );

  // Interrupt line, flopped so it stands clean for the host.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_flags & irq_mask_reg);
  end

  // Software writable registers; channel reset wipes every enable but leaves the interrupt mask.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_enable_reg <= 8'h00;
      tx_src_en_reg <= '0;
      rx_src_en_reg <= '0;
      tx_threshold_reg <= `TX_THRESHOLD_RESET;
      control_reg <= `CTL_RESET_VALUE;
      irq_mask_reg <= '0;
    end
    else if (chan_reset)
    begin
      int_enable_reg <= 8'h00;
      tx_src_en_reg <= '0;
      rx_src_en_reg <= '0;
      tx_threshold_reg <= `TX_THRESHOLD_RESET;
      control_reg <= `CTL_RESET_VALUE;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_INT_ENABLE_ZERO: int_enable_reg <= pwdata[7:0] & `REQ_MASK;
        `OFS_TX_SRC_ENABLE: tx_src_en_reg <= pwdata[`TX_SRC_COUNT-1:0];
        `OFS_RX_SRC_ENABLE: rx_src_en_reg <= pwdata[`RX_SRC_COUNT-1:0];
        `OFS_TX_THRESHOLD: tx_threshold_reg <= pwdata[7:0];
        `OFS_CONTROL: control_reg <= pwdata[7:0];
        `OFS_IRQ_MASK: irq_mask_reg <= pwdata[`IRQ_EVENT_COUNT-1:0];
        default: ;
      endcase
    end
  end

  // Read decode; unmapped addresses answer with an error and zero data.
  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `OFS_STATUS_ZERO: rd_data[7:0] = status_zero;
      `OFS_INT_ENABLE_ZERO: rd_data[7:0] = int_enable_reg;
      `OFS_TX_SRC_STATUS: rd_data[`TX_SRC_COUNT-1:0] = tx_src_flags;
      `OFS_TX_SRC_ENABLE: rd_data[`TX_SRC_COUNT-1:0] = tx_src_en_reg;
      `OFS_RX_SRC_STATUS: rd_data[`RX_SRC_COUNT-1:0] = rx_src_flags;
      `OFS_RX_SRC_ENABLE: rd_data[`RX_SRC_COUNT-1:0] = rx_src_en_reg;
      `OFS_FRAME_RESULT: rd_data[`RX_SRC_COUNT-1:0] = frame_result_reg;
      `OFS_TX_THRESHOLD: rd_data[7:0] = tx_threshold_reg;
      `OFS_CONTROL: rd_data[7:0] = control_reg;
      `OFS_IRQ_STATUS: rd_data[`IRQ_EVENT_COUNT-1:0] = irq_flags;
      `OFS_IRQ_MASK: rd_data[`IRQ_EVENT_COUNT-1:0] = irq_mask_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !addr_ok;
      if (access && !pwrite)
        prdata <= rd_data;
    end
  end

endmodule : serial_channel_irq

// ===== hdl/serial_irq_pkg.sv
// Types shared by the channel interrupt logic.
package serial_irq_pkg;
  // Protocol mode of the channel, one-hot.
  typedef enum logic [2:0] {
    MODE_ASYNC = 3'b001,
    MODE_BYTE_SYNC = 3'b010,
    MODE_BIT_SYNC = 3'b100
  } proto_mode_e;
endpackage : serial_irq_pkg

// ===== hdl/serial_irq_regs.svh
// Register offsets, field positions, reset values and widths of the channel.
`ifndef SERIAL_IRQ_REGS_SVH
`define SERIAL_IRQ_REGS_SVH
`define OFS_STATUS_ZERO 12'h000
`define OFS_INT_ENABLE_ZERO 12'h004
`define OFS_TX_SRC_STATUS 12'h008
`define OFS_TX_SRC_ENABLE 12'h00C
`define OFS_RX_SRC_STATUS 12'h010
`define OFS_RX_SRC_ENABLE 12'h014
`define OFS_FRAME_RESULT 12'h018
`define OFS_TX_THRESHOLD 12'h01C
`define OFS_CONTROL 12'h020
`define OFS_IRQ_STATUS 12'h024
`define OFS_IRQ_MASK 12'h028
`define BIT_TX_SUMMARY 7
`define BIT_RX_SUMMARY 6
`define BIT_RX_DATA 1
`define BIT_TX_SPACE 0
`define REQ_MASK 8'hC3
`define TX_UNDERFLOW 0
`define TX_QUIET 1
`define TX_CTS_CHANGE 2
`define RX_CARRIER 1
`define RX_PMP 5
`define RX_CRC 9
`define RX_FRAME_END_STATUS 10
`define RX_FRAME_BITS 12'h3F0
`define CTL_MODE_LSB 0
`define CTL_SINGLE_BYTE_HOST 3
`define CTL_TX_ENABLE 4
`define CTL_CHAN_RESET 8
`define CTL_TX_RESET 9
`define CTL_RX_RESET 10
`define CTL_RESET_VALUE 8'h01
`define TX_THRESHOLD_RESET 8'h00
`define FILL_WIDTH 6
`define TX_SRC_COUNT 3
`define RX_SRC_COUNT 12
`define IRQ_EVENT_COUNT 4
`endif

// ===== hdl/sticky_flag_bank.sv
// Bank of sticky flags with write-one-to-clear and hardware clears.
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear terms, one bit per flag except force_clear, which clears the whole bank.
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] w1c_mask,
  input wire logic [WIDTH-1:0] hw_clear,
  input wire logic force_clear,
  // Flag state.
  output logic [WIDTH-1:0] flags
);

  // Elaboration stops on a bank with no flags in it.
  if (WIDTH < 1)
  begin : g_bad_width
    $error("sticky_flag_bank needs at least one flag");
  end

  // Each flag keeps its event: a set in the cycle of a clear wins.
  // Only force_clear overrides a set; the channel reset with the transmit or receive reset drives it in the source banks, the interrupt bank ties it low.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_flag
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        flags[i] <= 1'b0;
      else if (force_clear)
        flags[i] <= 1'b0;
      else if (set_pulse[i])
        flags[i] <= 1'b1;
      else if (w1c_mask[i] || hw_clear[i])
        flags[i] <= 1'b0;
    end
  end

endmodule : sticky_flag_bank

// ===== testbench/chan_model.sv
// Far-side channel model holding the transmit and receive byte counts.
`timescale 1ns/1ps
module chan_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Buffer strobes.
  input wire logic tx_buffer_write,
  input wire logic tx_drain,
  input wire logic rx_push,
  input wire logic rx_buffer_read,
  // Buffer levels.
  output logic [5:0] tx_fill_count,
  output logic [5:0] rx_fill_count
);
  // A host write adds a byte that the line later drains.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_fill_count <= 6'h00;
    else
      tx_fill_count <= tx_fill_count + 6'(tx_buffer_write) - 6'(tx_drain);
  end
  // Each host read frees one byte and exposes the next.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_fill_count <= 6'h00;
    else
      rx_fill_count <= rx_fill_count + 6'(rx_push) - 6'(rx_buffer_read);
  end
endmodule : chan_model

// ===== testbench/serial_channel_irq_asserts.sv
// Port-level assertions for the channel interrupt logic, with its bind.
`timescale 1ns/1ps
`include "serial_irq_regs.svh"
module serial_channel_irq_asserts #(
  parameter int FILL_W = 6
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel side.
  input wire logic [FILL_W-1:0] tx_fill_count,
  input wire logic [FILL_W-1:0] rx_fill_count,
  input wire logic tx_underflow_event,
  // Requests.
  input wire logic tx_space_request,
  input wire logic rx_data_request,
  input wire logic tx_summary_request,
  input wire logic rx_summary_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ie_reg;
  logic [7:0] thr_reg;
  logic tx_on_reg;
  logic [2:0] tse_reg;
  logic wr;
  logic [3:0] req;
  logic [3:0] ien;
  // Accepted writes only; a refused write must not move the shadows.
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign req = {tx_summary_request, rx_summary_request, rx_data_request,
                tx_space_request};
  assign ien = {ie_reg[7:6], ie_reg[1:0]};
  // Shadows of the settings the checks need; a channel reset wipes them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {ie_reg, thr_reg, tx_on_reg, tse_reg} <= '0;
    else if (wr && paddr == `OFS_CONTROL && pwdata[`CTL_CHAN_RESET])
      {ie_reg, thr_reg, tx_on_reg, tse_reg} <= '0;
    else if (wr && paddr == `OFS_INT_ENABLE_ZERO)
      ie_reg <= pwdata[7:0] & `REQ_MASK;
    else if (wr && paddr == `OFS_TX_THRESHOLD)
      thr_reg <= pwdata[7:0];
    else if (wr && paddr == `OFS_CONTROL)
      tx_on_reg <= pwdata[`CTL_TX_ENABLE];
    else if (wr && paddr == `OFS_TX_SRC_ENABLE)
      tse_reg <= pwdata[2:0];
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  access_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && pready && paddr > 12'h028
    |-> pslverr) else $error("unmapped access not refused");
  enable_gate_a: assert property ((req & ~$past(ien)) == 4'h0)
    else $error("request raised with its enable clear");
  tx_space_drop_a: assert property (!tx_on_reg ||
    8'(tx_fill_count) > thr_reg |-> ##2 !tx_space_request)
    else $error("transmit space request not withdrawn");
  rx_empty_drop_a: assert property (rx_fill_count == '0
    |-> ##2 !rx_data_request) else $error("receive request with empty buffer");
  underflow_req_a: assert property (tx_underflow_event && tse_reg[0]
    && ie_reg[7] |-> ##2 tx_summary_request)
    else $error("underflow did not raise transmit summary request");
  cover property ($rose(tx_summary_request));
  cover property ($fell(rx_data_request));
  cover property (pslverr);
endmodule : serial_channel_irq_asserts

bind serial_channel_irq serial_channel_irq_asserts #(.FILL_W(FILL_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .tx_fill_count, .rx_fill_count, .tx_underflow_event,
  .tx_space_request, .rx_data_request, .tx_summary_request,
  .rx_summary_request
);

// ===== testbench/tb_top.sv
// Self-checking bench for the channel interrupt logic.
`timescale 1ns/1ps
`include "serial_irq_regs.svh"
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module tb_top;
  localparam logic [18:0] uf = 19'h01000, qt = 19'h02000, tw = 19'h04000;
  localparam logic [18:0] rr = 19'h08000, fl = 19'h10000, rp = 19'h20000;
  localparam logic [18:0] td = 19'h40000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, v, m, exp;
  logic [5:0] tx_fill_count, rx_fill_count;
  logic [18:0] ev;
  logic clear_to_send_level, carrier_level, check_code_ok, rx_read_next_pmp;
  logic tx_space_request, rx_data_request;
  logic tx_summary_request, rx_summary_request;
  int n_fail = 0, cmp_count = 0, cyc = 0, i;

  serial_channel_irq #(.FILL_W(6)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_fill_count, .rx_fill_count,
    .tx_buffer_write(ev[14]), .rx_buffer_read(ev[15]), .rx_read_next_pmp,
    .rx_frame_last_read(ev[16]), .tx_underflow_event(ev[12]),
    .tx_quiet_event(ev[13]), .clear_to_send_level, .carrier_level,
    .rx_source_event(ev[11:0]), .check_code_ok, .tx_space_request,
    .rx_data_request, .tx_summary_request, .rx_summary_request, .irq);
  chan_model u_chan (.pclk, .presetn, .tx_buffer_write(ev[14]),
    .tx_drain(ev[18]), .rx_push(ev[17]), .rx_buffer_read(ev[15]),
    .tx_fill_count, .rx_fill_count);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are counted at rising edges, where pready is sampled.
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    n_fail += (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  // Event strobes last exactly one cycle.
  task automatic pulse(input logic [18:0] p);
    @(posedge pclk);
    ev <= p;
    @(posedge pclk);
    ev <= '0;
  endtask : pulse
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask : wt
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {clear_to_send_level, carrier_level, check_code_ok} = '0;
    rx_read_next_pmp = 1'b0;
    seed = 32'hBC590C1F;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFS_CONTROL, 32'h1);
    rdchk(`OFS_STATUS_ZERO, 32'h0);
    apb(1'b1, 12'h100, 32'hFF);
    `CHK(er, 1'b1)
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, `OFS_CONTROL, 32'h1 << i);
      rdchk(`OFS_CONTROL, 32'h1 << i);
    end
    // Transmit space around the threshold boundary.
    apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'hFF);
    rdchk(`OFS_INT_ENABLE_ZERO, 32'hC3);
    apb(1'b1, `OFS_TX_THRESHOLD, 32'h3);
    apb(1'b1, `OFS_CONTROL, 32'h11);
    wt(3);
    `CHK(tx_space_request, 1'b1)
    for (i = 0; i < 4; i++)
    begin
      pulse(tw);
      wt(3);
      `CHK(tx_space_request, i < 3)
    end
    repeat (4) pulse(td);
    wt(3);
    `CHK(tx_space_request, 1'b1)
    apb(1'b1, `OFS_CONTROL, 32'h211);
    wt(2);
    `CHK(tx_space_request, 1'b0)
    apb(1'b1, `OFS_CONTROL, 32'h01);
    wt(3);
    `CHK(tx_space_request, 1'b0)
    // Transmit sources, summary shown with its enable clear.
    apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'h43);
    apb(1'b1, `OFS_TX_SRC_ENABLE, 32'h7);
    for (i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      clear_to_send_level <= clear_to_send_level ^ (i == 2);
      pulse(i == 0 ? uf : i == 1 ? qt : 19'h0);
      rdchk(`OFS_TX_SRC_STATUS, 32'h1 << i);
      rdchk(`OFS_STATUS_ZERO, 32'h80);
      `CHK(tx_summary_request, 1'b0)
      apb(1'b1, `OFS_TX_SRC_STATUS, 32'h0);
      rdchk(`OFS_TX_SRC_STATUS, 32'h1 << i);
      if (i == 1)
        pulse(tw);
      else
        apb(1'b1, `OFS_TX_SRC_STATUS, 32'h1 << i);
      rdchk(`OFS_TX_SRC_STATUS, 32'h0);
    end
    // Interrupt raised, masked and cleared.
    apb(1'b1, `OFS_INT_ENABLE_ZERO, 32'hC3);
    apb(1'b1, `OFS_IRQ_STATUS, 32'hF);
    apb(1'b1, `OFS_IRQ_MASK, 32'h8);
    pulse(uf);
    wt(3);
    `CHK(tx_summary_request, 1'b1)
    `CHK(irq, 1'b1)
    rdchk(`OFS_IRQ_STATUS, 32'h8);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    wt(2);
    `CHK(irq, 1'b0)
    apb(1'b1, `OFS_TX_SRC_STATUS, 32'h1);
    wt(2);
    `CHK(tx_summary_request, 1'b0)
    apb(1'b1, `OFS_IRQ_STATUS, 32'h8);
    rdchk(`OFS_IRQ_STATUS, 32'h0);
    // Random receive events against write-one clears.
    apb(1'b1, `OFS_RX_SRC_ENABLE, 32'hFFF);
    exp = 32'h0;
    for (i = 0; i < 24; i++)
    begin
      v = rnd() & 32'hFFF;
      pulse(19'(v[11:0]));
      exp |= v;
      rdchk(`OFS_RX_SRC_STATUS, exp);
      `CHK(rx_summary_request, |exp)
      m = rnd() & 32'hFFF;
      apb(1'b1, `OFS_RX_SRC_STATUS, m);
      exp &= ~m;
      rdchk(`OFS_RX_SRC_STATUS, exp);
    end
    apb(1'b1, `OFS_RX_SRC_STATUS, 32'hFFF);
    // Receive data request until the buffer is empty.
    repeat (2) pulse(rp);
    wt(3);
    `CHK(rx_data_request, 1'b1)
    pulse(rr);
    wt(3);
    `CHK(rx_data_request, 1'b1)
    pulse(rr);
    wt(3);
    `CHK(rx_data_request, 1'b0)
    // Carrier change, then a receive reset with a byte still buffered.
    @(posedge pclk);
    carrier_level <= 1'b1;
    pulse(rp);
    rdchk(`OFS_RX_SRC_STATUS, 32'h2);
    apb(1'b1, `OFS_CONTROL, 32'h401);
    wt(2);
    `CHK(rx_data_request, 1'b0)
    pulse(rr);
    // Parity flag read-clear with one and with two zero bits.
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `OFS_CONTROL, i ? 32'h01 : 32'h09);
      repeat (2) pulse(rp);
      pulse(19'h00020);
      pulse(rr);
      rdchk(`OFS_RX_SRC_STATUS, i ? 32'h20 : 32'h0);
      pulse(rr);
      rdchk(`OFS_RX_SRC_STATUS, 32'h0);
    end
    // A set parity bit on the next byte keeps the flag.
    apb(1'b1, `OFS_CONTROL, 32'h09);
    pulse(rp);
    pulse(19'h00020);
    rx_read_next_pmp <= 1'b1;
    pulse(rr);
    rdchk(`OFS_RX_SRC_STATUS, 32'h20);
    rx_read_next_pmp <= 1'b0;
    apb(1'b1, `OFS_RX_SRC_STATUS, 32'h20);
    // Check-code fault clears once the result is good.
    apb(1'b1, `OFS_CONTROL, 32'h02);
    pulse(19'h00200);
    rdchk(`OFS_RX_SRC_STATUS, 32'h200);
    @(posedge pclk);
    check_code_ok <= 1'b1;
    rdchk(`OFS_RX_SRC_STATUS, 32'h0);
    check_code_ok <= 1'b0;
    // Frame completion moves the frame bits out of the live flags.
    apb(1'b1, `OFS_CONTROL, 32'h04);
    v = (rnd() & 32'h3F0) | 32'h10;
    pulse(19'(v[11:0]));
    pulse(fl);
    rdchk(`OFS_RX_SRC_STATUS, 32'h400);
    rdchk(`OFS_FRAME_RESULT, v);
    apb(1'b1, `OFS_CONTROL, 32'h100);
    rdchk(`OFS_RX_SRC_STATUS, 32'h0);
    rdchk(`OFS_INT_ENABLE_ZERO, 32'h0);
    rdchk(`OFS_RX_SRC_ENABLE, 32'h0);
    rdchk(`OFS_FRAME_RESULT, 32'h0);
    results();
  end
endmodule : tb_top
